/* File: gat_pkg.sv */
// Purpose: shared constants for the guaranteed-access memory handshake
// Assumes: one 10 MHz clock on both ends
// Notes:   times are kept in ns, cycle counts are derived from them
package gat_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // acknowledge must follow a request within this time (longest, rounds down)
  localparam int ACK_TIME_NS   = 200;
  localparam int ACK_CYCLES    = (ACK_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : ACK_TIME_NS / CLK_PERIOD_NS;
  // total extension allowed for an EISA or ISA cycle (longest, rounds down)
  localparam int GAT_MAX_NS     = 2100;
  localparam int GAT_MAX_CYCLES = (GAT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : GAT_MAX_NS / CLK_PERIOD_NS;
  // longest wait behind a processor fill with victim (longest, rounds down)
  localparam int FILL_WAIT_NS     = 400;
  localparam int FILL_WAIT_CYCLES = (FILL_WAIT_NS / CLK_PERIOD_NS) < 1 ? 1 : FILL_WAIT_NS / CLK_PERIOD_NS;
  localparam int LAT_CNT_W        = 5;
  localparam int FILL_CNT_W       = 3;
  // scatter/gather TLB entry: 4 page entries of 8 KB = 32 KB aligned span
  localparam int SG_PAGE_BYTES    = 8192;
  localparam int SG_PTES_PER_TLB  = 4;
  localparam int SG_SPAN_LSB      = $clog2(SG_PAGE_BYTES * SG_PTES_PER_TLB);
  localparam int DMA_ADDR_W       = 32;
  // requester kinds seen by the bridge end
  typedef enum logic [1:0] {
    KIND_BRIDGE = 2'h0,
    KIND_EISA   = 2'h1,
    KIND_ISA    = 2'h2,
    KIND_DMA    = 2'h3
  } master_kind_t;
endpackage

/* File: gat_if.sv */
// Purpose: sideband handshake between the EISA bridge and the host bridge
// Assumes: all three lines are active low, driven by one end each
// Notes:   no clocking block; the testbench joins the two ends here
`timescale 1ns/1ps
`default_nettype none
interface gat_if;
  logic flush_request_n;
  logic memory_request_n;
  logic memory_acknowledge_n;
  modport host_end (
    input  flush_request_n,
    input  memory_request_n,
    output memory_acknowledge_n
  );
  modport bridge_end (
    output flush_request_n,
    output memory_request_n,
    input  memory_acknowledge_n
  );
endinterface
`default_nettype wire

/* File: gat_host_end.sv */
// Purpose: host bridge side of the guaranteed-access memory handshake
// Assumes: i_flush_enable, i_stall_enable, i_gat_enable are the control register bits
// Notes:   one posted I/O write entry; reads wait for it to drain
`timescale 1ns/1ps
`default_nettype none
module gat_host_end #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  gat_if.host_end                           link,
  input  wire logic                         i_gat_enable,
  input  wire logic                         i_flush_enable,
  input  wire logic                         i_stall_enable,
  input  wire logic                         i_io_wr_valid,
  input  wire logic [AW-1:0]                i_io_wr_addr,
  input  wire logic [DW-1:0]                i_io_wr_data,
  output logic                              o_io_wr_ready,
  output logic                              o_pci_wr_valid,
  output logic [AW-1:0]                     o_pci_wr_addr,
  output logic [DW-1:0]                     o_pci_wr_data,
  input  wire logic                         i_pci_wr_ready,
  input  wire logic                         i_io_rd_valid,
  output logic                              o_io_rd_grant,
  input  wire logic                         i_fill_busy,
  output logic                              o_cpu_stall,
  output logic                              o_cpu_io_hold,
  output logic                              o_refresh_pulse,
  input  wire logic [gat_pkg::DMA_ADDR_W-1:0] i_dma_addr,
  input  wire logic                         i_tlb_locked,
  output logic                              o_sg_boundary_warn,
  output logic                              o_latency_overrun
);
  import gat_pkg::*;

  // refuse widths the datapath cannot hold, and a latency counter too narrow for the budget
  if (AW < 1 || DW < 1 || GAT_MAX_CYCLES >= (1 << LAT_CNT_W)) begin : g_param_check
    $error("gat_host_end: unsupported width or counter size");
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_FLUSH = 4'h2,
    S_FILL  = 4'h4,
    S_ACK   = 4'h8
  } host_state_t;

  logic req_seen;
  // with GAT on both lines mean the same thing, so only the flush line counts
  always_comb begin
    if (i_gat_enable) begin
      req_seen = !link.flush_request_n;
    end else begin
      req_seen = !link.flush_request_n || !link.memory_request_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  host_state_t                         state_ff, nxt_state;
  logic                                buf_valid_ff, nxt_buf_valid;
  logic [AW-1:0]                       buf_addr_ff, nxt_buf_addr;
  logic [DW-1:0]                       buf_data_ff, nxt_buf_data;
  logic                                wr_ready_ff, nxt_wr_ready;
  logic                                rd_grant_ff, nxt_rd_grant;
  logic                                ack_ff, nxt_ack;
  logic                                stall_ff, nxt_stall;
  logic                                io_hold_ff, nxt_io_hold;
  logic                                refresh_ff, nxt_refresh;
  logic                                warn_ff, nxt_warn;
  logic                                overrun_ff, nxt_overrun;
  logic [LAT_CNT_W-1:0]                lat_ff, nxt_lat;
  logic [FILL_CNT_W-1:0]               fill_ff, nxt_fill;
  logic [DMA_ADDR_W-1:SG_SPAN_LSB]     span_ff, nxt_span;
  logic                                flush_on_ff, nxt_flush_on;

  logic accept;
  logic drain;
  logic block_wr;

  always_comb begin
    nxt_state    = state_ff;
    nxt_ack      = ack_ff;
    nxt_refresh  = 1'b0;
    nxt_lat      = lat_ff;
    nxt_fill     = fill_ff;
    nxt_span     = span_ff;
    nxt_warn     = warn_ff;
    nxt_overrun  = overrun_ff;
    nxt_flush_on = flush_on_ff;
    accept       = i_io_wr_valid && wr_ready_ff;
    drain        = buf_valid_ff && i_pci_wr_ready;
    case (state_ff)
      S_IDLE: begin
        nxt_ack = 1'b0;
        if (req_seen) begin
          nxt_lat      = '0;
          nxt_fill     = '0;
          nxt_warn     = 1'b0;
          nxt_overrun  = 1'b0;
          nxt_flush_on = i_flush_enable;
          nxt_state    = i_flush_enable ? S_FLUSH : S_FILL;
        end
      end
      S_FLUSH: begin
        nxt_lat = lat_ff + 1'b1;
        // the buffer drains through the normal PCI path; writes are blocked
        if (!buf_valid_ff || drain) begin
          nxt_state = S_FILL;
        end
      end
      S_FILL: begin
        nxt_lat = lat_ff + 1'b1;
        // stall mode cuts off the processor, so no fill can be in the way
        if (!i_stall_enable && i_fill_busy &&
            fill_ff < FILL_CNT_W'(FILL_WAIT_CYCLES)) begin
          nxt_fill = fill_ff + 1'b1;
        end else begin
          nxt_state   = S_ACK;
          nxt_ack     = 1'b1;
          nxt_refresh = 1'b1;
          nxt_span    = i_dma_addr[DMA_ADDR_W-1:SG_SPAN_LSB];
        end
      end
      S_ACK: begin
        if (!i_tlb_locked && i_dma_addr[DMA_ADDR_W-1:SG_SPAN_LSB] != span_ff) begin
          nxt_warn = 1'b1;
        end
        if (!req_seen) begin
          nxt_ack   = 1'b0;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_ack   = 1'b0;
      end
    endcase
    // latency to acknowledge must stay inside the extension budget
    if ((state_ff == S_FLUSH || state_ff == S_FILL) &&
        lat_ff >= LAT_CNT_W'(GAT_MAX_CYCLES - 1)) begin
      nxt_overrun = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // processor side: single posted entry, read ordering, stall and hold

  always_comb begin
    nxt_stall   = (nxt_state == S_ACK) && i_stall_enable;
    nxt_io_hold = (nxt_state == S_ACK) && !i_stall_enable;
    // blocking covers the whole transaction while flushing is on; a write taken
    // between drain and acknowledge would refill the entry the flush just emptied
    block_wr    = (nxt_state == S_FLUSH) ||
                  (nxt_state == S_FILL && nxt_flush_on) ||
                  (nxt_state == S_ACK && (nxt_flush_on || nxt_stall || nxt_io_hold));
    nxt_buf_valid = buf_valid_ff;
    nxt_buf_addr  = buf_addr_ff;
    nxt_buf_data  = buf_data_ff;
    if (drain) begin
      nxt_buf_valid = 1'b0;
    end
    if (accept) begin
      nxt_buf_valid = 1'b1;
      nxt_buf_addr  = i_io_wr_addr;
      nxt_buf_data  = i_io_wr_data;
    end
    nxt_wr_ready = !nxt_buf_valid && !block_wr && !i_io_rd_valid;
    // a read is granted only once the posted entry has left
    nxt_rd_grant = i_io_rd_valid && !rd_grant_ff && !buf_valid_ff &&
                   !accept && !nxt_io_hold && !nxt_stall;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff     <= S_IDLE;
      buf_valid_ff <= 1'b0;
      buf_addr_ff  <= '0;
      buf_data_ff  <= '0;
      wr_ready_ff  <= 1'b0;
      rd_grant_ff  <= 1'b0;
      ack_ff       <= 1'b0;
      stall_ff     <= 1'b0;
      io_hold_ff   <= 1'b0;
      refresh_ff   <= 1'b0;
      warn_ff      <= 1'b0;
      overrun_ff   <= 1'b0;
      lat_ff       <= '0;
      fill_ff      <= '0;
      span_ff      <= '0;
      flush_on_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      buf_valid_ff <= nxt_buf_valid;
      buf_addr_ff  <= nxt_buf_addr;
      buf_data_ff  <= nxt_buf_data;
      wr_ready_ff  <= nxt_wr_ready;
      rd_grant_ff  <= nxt_rd_grant;
      ack_ff       <= nxt_ack;
      stall_ff     <= nxt_stall;
      io_hold_ff   <= nxt_io_hold;
      refresh_ff   <= nxt_refresh;
      warn_ff      <= nxt_warn;
      overrun_ff   <= nxt_overrun;
      lat_ff       <= nxt_lat;
      fill_ff      <= nxt_fill;
      span_ff      <= nxt_span;
      flush_on_ff  <= nxt_flush_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign link.memory_acknowledge_n = !ack_ff;
  assign o_io_wr_ready       = wr_ready_ff;
  assign o_pci_wr_valid      = buf_valid_ff;
  assign o_pci_wr_addr       = buf_addr_ff;
  assign o_pci_wr_data       = buf_data_ff;
  assign o_io_rd_grant       = rd_grant_ff;
  assign o_cpu_stall         = stall_ff;
  assign o_cpu_io_hold       = io_hold_ff;
  assign o_refresh_pulse     = refresh_ff;
  assign o_sg_boundary_warn  = warn_ff;
  assign o_latency_overrun   = overrun_ff;
endmodule
`default_nettype wire

/* File: gat_bridge_end.sv */
// Purpose: EISA bridge side of the guaranteed-access memory handshake
// Assumes: one cycle request is presented at a time, held until o_cycle_go
// Notes:   PCI-to-EISA posting is off, so PCI masters are retried instead
`timescale 1ns/1ps
`default_nettype none
module gat_bridge_end (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  gat_if.bridge_end                  link,
  input  wire logic                  i_cycle_req,
  input  wire logic                  i_cycle_refresh,
  input  wire gat_pkg::master_kind_t i_master_kind,
  input  wire logic                  i_cycle_done,
  output logic                       o_cycle_go,
  output logic                       o_pci_retry,
  output logic                       o_wait_overrun
);
  import gat_pkg::*;

  typedef enum logic [2:0] {
    B_IDLE = 3'h1,
    B_REQ  = 3'h2,
    B_OWN  = 3'h4
  } bridge_state_t;

  bridge_state_t        state_ff, nxt_state;
  logic                 memory_request_n_ff, nxt_memory_request_n;
  logic                 flushreq_ff, nxt_flushreq;
  logic                 go_ff, nxt_go;
  logic                 retry_ff, nxt_retry;
  logic                 over_ff, nxt_over;
  logic [LAT_CNT_W-1:0] wait_ff, nxt_wait;

  ////////////////////////////////////////////////////////////////////////////
  // handshake sequencing

  always_comb begin
    nxt_state    = state_ff;
    nxt_memory_request_n   = memory_request_n_ff;
    nxt_flushreq = flushreq_ff;
    nxt_go       = go_ff;
    nxt_wait     = wait_ff;
    nxt_over     = over_ff;
    case (state_ff)
      B_IDLE: begin
        if (i_cycle_req && i_cycle_refresh) begin
          nxt_go    = 1'b1;
          nxt_state = B_OWN;
        end else if (i_cycle_req) begin
          nxt_memory_request_n   = 1'b1;
          nxt_flushreq = (i_master_kind != KIND_BRIDGE);
          nxt_wait     = '0;
          nxt_over     = 1'b0;
          nxt_state    = B_REQ;
        end
      end
      B_REQ: begin
        nxt_wait = wait_ff + 1'b1;
        if (!link.memory_acknowledge_n) begin
          nxt_go    = 1'b1;
          nxt_state = B_OWN;
        end else if (wait_ff >= LAT_CNT_W'(GAT_MAX_CYCLES - 1)) begin
          nxt_over = 1'b1;
        end
      end
      B_OWN: begin
        if (i_cycle_done) begin
          nxt_go       = 1'b0;
          nxt_memory_request_n   = 1'b0;
          nxt_flushreq = 1'b0;
          nxt_state    = B_IDLE;
        end
      end
      default: begin
        nxt_state    = B_IDLE;
        nxt_go       = 1'b0;
        nxt_memory_request_n   = 1'b0;
        nxt_flushreq = 1'b0;
      end
    endcase
    // a PCI master is turned away until this side owns the EISA bus
    nxt_retry = (nxt_state == B_REQ) || (nxt_state == B_IDLE && i_cycle_req);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff    <= B_IDLE;
      memory_request_n_ff   <= 1'b0;
      flushreq_ff <= 1'b0;
      go_ff       <= 1'b0;
      retry_ff    <= 1'b0;
      over_ff     <= 1'b0;
      wait_ff     <= '0;
    end else begin
      state_ff    <= nxt_state;
      memory_request_n_ff   <= nxt_memory_request_n;
      flushreq_ff <= nxt_flushreq;
      go_ff       <= nxt_go;
      retry_ff    <= nxt_retry;
      over_ff     <= nxt_over;
      wait_ff     <= nxt_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.memory_request_n = !memory_request_n_ff;
  assign link.flush_request_n  = !flushreq_ff;
  assign o_cycle_go            = go_ff;
  assign o_pci_retry           = retry_ff;
  assign o_wait_overrun        = over_ff;
endmodule
`default_nettype wire

/* File: gat_props.sv */
// Purpose: protocol checks on the memory request handshake lines
// Assumes: both ends share i_clk and i_nrst
// Notes:   watches the interface lines only, never the user sides
`timescale 1ns/1ps
`default_nettype none
module gat_props import gat_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic flush_request_n,
  input wire logic memory_request_n,
  input wire logic memory_acknowledge_n
);
  // slowest legal ack still lands inside the total extension budget
  localparam int ACK_MAX = GAT_MAX_CYCLES;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////
  a_ack_needs_req: assert property ($fell(memory_acknowledge_n) |-> !(flush_request_n && memory_request_n))
    else $error("ack without request");
  a_ack_in_bound: assert property ($fell(flush_request_n) |-> ##[2:ACK_MAX] !memory_acknowledge_n)
    else $error("ack late");
  a_ack_not_early: assert property ($fell(flush_request_n) |-> memory_acknowledge_n [*2])
    else $error("ack before fill step");
  a_ack_holds: assert property (!memory_acknowledge_n && !memory_request_n |=> !memory_acknowledge_n)
    else $error("ack dropped early");
  a_ack_drops: assert property ($rose(memory_request_n) |-> ##[1:2] memory_acknowledge_n)
    else $error("ack not released");
  a_lines_paired: assert property (!flush_request_n |-> !memory_request_n)
    else $error("flush line without memory line");
  a_req_held: assert property (!memory_request_n && memory_acknowledge_n |=> !memory_request_n)
    else $error("request withdrawn before ack");
  a_req_gap: assert property ($rose(memory_request_n) |-> memory_request_n [*2])
    else $error("request before ack release");
  a_idle_quiet: assert property (memory_request_n && flush_request_n && memory_acknowledge_n |=> memory_acknowledge_n)
    else $error("ack while idle");
  c_ack: cover property ($fell(memory_acknowledge_n));
  c_plain_req: cover property ($fell(memory_request_n) && flush_request_n);
  c_long_wait: cover property ((!memory_request_n && memory_acknowledge_n) [*8]);
endmodule
`default_nettype wire

/* File: eisa_guaranteed_memory_access_tb_top.sv */
// Purpose: joins host and bridge ends and runs the handshake tests
// Assumes: 10 MHz clock, inputs driven at the falling edge
// Notes:   expected values are literals and test settings; only the fill bound uses a package constant
`timescale 1ns/1ps
`default_nettype none
module eisa_guaranteed_memory_access_tb_top;
  import gat_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_nrst = 1'b0;
  logic         gat_en = 1'b1, fl_en = 1'b0, st_en = 1'b1, fill = 1'b0, tlb_lock = 1'b0;
  logic         wr_valid = 1'b0, pci_rdy = 1'b1, rd_valid = 1'b0;
  logic [31:0]  wr_addr = 32'h0, wr_data = 32'h0, dma_addr = 32'h0000_7FF0;
  logic         cyc_req = 1'b0, cyc_ref = 1'b0, cyc_done = 1'b0;
  master_kind_t mkind = KIND_EISA;
  logic         o_io_wr_ready, o_pci_wr_valid, o_io_rd_grant, o_cpu_stall, o_cpu_io_hold;
  logic         o_refresh_pulse, o_sg_boundary_warn, o_latency_overrun, o_cycle_go, o_pci_retry, o_wait_overrun;
  logic [31:0]  o_pci_wr_addr, o_pci_wr_data;
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           n_cyc = 0;
  int           n_pulse = 0;
  gat_if link_if ();
  gat_host_end i_gat_host_end (.i_clk(i_clk), .i_nrst(i_nrst), .link(link_if), .i_gat_enable(gat_en),
    .i_flush_enable(fl_en), .i_stall_enable(st_en), .i_io_wr_valid(wr_valid), .i_io_wr_addr(wr_addr),
    .i_io_wr_data(wr_data), .o_io_wr_ready(o_io_wr_ready), .o_pci_wr_valid(o_pci_wr_valid),
    .o_pci_wr_addr(o_pci_wr_addr), .o_pci_wr_data(o_pci_wr_data), .i_pci_wr_ready(pci_rdy),
    .i_io_rd_valid(rd_valid), .o_io_rd_grant(o_io_rd_grant), .i_fill_busy(fill), .o_cpu_stall(o_cpu_stall),
    .o_cpu_io_hold(o_cpu_io_hold), .o_refresh_pulse(o_refresh_pulse), .i_dma_addr(dma_addr),
    .i_tlb_locked(tlb_lock), .o_sg_boundary_warn(o_sg_boundary_warn), .o_latency_overrun(o_latency_overrun));
  gat_bridge_end i_gat_bridge_end (.i_clk(i_clk), .i_nrst(i_nrst), .link(link_if), .i_cycle_req(cyc_req),
    .i_cycle_refresh(cyc_ref), .i_master_kind(mkind), .i_cycle_done(cyc_done), .o_cycle_go(o_cycle_go),
    .o_pci_retry(o_pci_retry), .o_wait_overrun(o_wait_overrun));
  gat_props i_props (.i_clk(i_clk), .i_nrst(i_nrst), .flush_request_n(link_if.flush_request_n),
    .memory_request_n(link_if.memory_request_n), .memory_acknowledge_n(link_if.memory_acknowledge_n));
  ////////////////////////////////////////////////////////////////////////
  always #50 i_clk = ~i_clk;
  // the whole run needs well under 1000 cycles; 3000 leaves room for slow paths
  always @(posedge i_clk) begin
    n_cyc <= n_cyc + 1;
    if (o_refresh_pulse === 1'b1) n_pulse = n_pulse + 1;
    if (n_cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic io_write(input logic [31:0] a, input logic [31:0] d);
    int k = 0;
    while (o_io_wr_ready !== 1'b1 && k < 40) begin
      @(negedge i_clk);
      k++;
    end
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge i_clk);
    wr_valid = 1'b0;
    check("pci valid", o_pci_wr_valid, 1'b1);
    check("pci addr", o_pci_wr_addr, a);
    check("pci data", o_pci_wr_data, d);
  endtask
  // rel: wait step at which the write path is opened and the mode bit dropped
  task automatic eisa_cycle(input logic [1:0] kind, input logic [31:0] a2, input logic warn, input int rel,
                            output int lat);
    logic seen_retry;
    lat = 0;
    seen_retry = 1'b0;
    dma_addr = 32'h0000_7FF0;
    n_pulse = 0;
    cyc_req = 1'b1;
    mkind = master_kind_t'(kind);
    while (o_cycle_go !== 1'b1 && lat < 60) begin
      @(negedge i_clk);
      lat++;
      if (o_pci_retry === 1'b1) seen_retry = 1'b1;
      if (fl_en && lat == rel + 1) check("blocked in fill", o_io_wr_ready, 1'b0);
      if (lat == rel) begin
        check("ack early", link_if.memory_acknowledge_n, 1'b1);
        check("wait overrun", o_wait_overrun, rel > 21);
        pci_rdy = 1'b1;
        gat_en = 1'b0;
      end
    end
    cyc_req = 1'b0;
    dma_addr = a2;
    check("go", o_cycle_go, 1'b1);
    check("retry", seen_retry, 1'b1);
    check("flush line", link_if.flush_request_n, kind == 2'h0);
    check("stall", o_cpu_stall, st_en);
    check("io hold", o_cpu_io_hold, !st_en);
    check("wr ready", o_io_wr_ready, 1'b0);
    check("refresh pulses", n_pulse, 1);
    check("host overrun", o_latency_overrun, 1'b0);
    if (fl_en) check("drained", o_pci_wr_valid, 1'b0);
    @(negedge i_clk);
    cyc_done = 1'b1;
    @(negedge i_clk);
    cyc_done = 1'b0;
    repeat (3) @(negedge i_clk);
    check("stall off", o_cpu_stall, 1'b0);
    check("hold off", o_cpu_io_hold, 1'b0);
    check("ack off", link_if.memory_acknowledge_n, 1'b1);
    check("span warn", o_sg_boundary_warn, warn);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int lat;
    int lat_fast;
    int k;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    cyc_ref = 1'b1;
    cyc_req = 1'b1;
    repeat (2) @(negedge i_clk);
    check("refresh go", o_cycle_go, 1'b1);
    check("refresh quiet", link_if.memory_request_n, 1'b1);
    cyc_req = 1'b0;
    cyc_done = 1'b1;
    @(negedge i_clk);
    cyc_done = 1'b0;
    cyc_ref = 1'b0;
    $display("test refresh done");
    for (k = 1; k < 4; k++) eisa_cycle(k[1:0], 32'h0000_7FF8, 1'b0, -1, lat);
    eisa_cycle(2'h3, 32'h0000_8000, 1'b1, -1, lat);
    tlb_lock = 1'b1;
    eisa_cycle(2'h3, 32'h0000_8000, 1'b0, -1, lat);
    tlb_lock = 1'b0;
    $display("test stall mode done");
    st_en = 1'b0;
    for (k = 1; k < 4; k++) eisa_cycle(k[1:0], 32'h0000_7FF8, 1'b0, -1, lat_fast);
    fill = 1'b1;
    eisa_cycle(2'h2, 32'h0000_7FF8, 1'b0, -1, lat);
    fill = 1'b0;
    check("fill delays", lat > lat_fast, 1'b1);
    check("fill bound", lat <= lat_fast + FILL_WAIT_CYCLES, 1'b1);
    $display("test open mode done");
    pci_rdy = 1'b0;
    io_write(32'h0000_0300, 32'hA5A5_0001);
    eisa_cycle(2'h1, 32'h0000_7FF8, 1'b0, -1, lat);
    check("entry kept", o_pci_wr_valid, 1'b1);
    fl_en = 1'b1;
    eisa_cycle(2'h1, 32'h0000_7FF8, 1'b0, 6, lat);
    gat_en = 1'b1;
    fl_en = 1'b0;
    check("ack after drain", lat > 6, 1'b1);
    $display("test flush done");
    pci_rdy = 1'b0;
    io_write(32'h0000_0304, 32'h5A5A_0002);
    rd_valid = 1'b1;
    repeat (4) begin
      @(negedge i_clk);
      check("early grant", o_io_rd_grant, 1'b0);
    end
    pci_rdy = 1'b1;
    k = 0;
    while (o_io_rd_grant !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    rd_valid = 1'b0;
    check("grant", o_io_rd_grant, 1'b1);
    check("empty at grant", o_pci_wr_valid, 1'b0);
    $display("test read drain done");
    eisa_cycle(2'h0, 32'h0000_7FF8, 1'b0, 25, lat);
    gat_en = 1'b1;
    $display("test single line done");
    wrap_up();
  end
endmodule
`default_nettype wire
